/* File: hdl/rsc_pkg.sv */
// Purpose: shared constants for the reset source controller
// Assumes: 40 MHz controller clock, APB with 32-bit data
// Notes: register index is printed as a word offset; bus address is 4x
package rsc_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [11:0] RSC_CAUSE_INDEX = 12'h0ef;
  localparam logic [11:0] RSC_CAUSE_ADDR = 12'h3bc;
  localparam int RSC_ADDR_W = 12;

  // ***********************************************************
  // cause register fields
  // ***********************************************************
  localparam int RSC_PIN_BIT = 0;
  localparam int RSC_PWR_BIT = 1;
  localparam int RSC_LOST_BIT = 2;
  localparam int RSC_DOG_BIT = 3;
  localparam int RSC_SOFT_BIT = 4;
  localparam int RSC_CMP_BIT = 5;
  localparam int RSC_FLASH_BIT = 6;
  localparam int RSC_RTC_BIT = 7;

  // enables after a power-on reset; a power-fail reset reloads only pwr_en
  localparam logic RSC_PWR_EN_RST = 1'b1;
  localparam logic RSC_LOST_EN_RST = 1'b0;
  localparam logic RSC_CMP_EN_RST = 1'b0;
  localparam logic RSC_RTC_EN_RST = 1'b0;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int RSC_CLK_PERIOD_PS = 25000;
  localparam int RSC_LOST_TIMEOUT_US = 100;
  // least time: rounded up to whole cycles
  localparam int RSC_LOST_CYCLES =
    (RSC_LOST_TIMEOUT_US * 1000000 + RSC_CLK_PERIOD_PS - 1) /
    RSC_CLK_PERIOD_PS;
  localparam int RSC_DOG_DIV = 12;
  localparam logic [15:0] RSC_RESET_VECTOR = 16'h0000;

  // ***********************************************************
  // states and causes
  // ***********************************************************
  typedef enum logic {RSC_RUN, RSC_HOLD} rsc_state_e;
  typedef enum logic [3:0] {
    RSC_C_NONE, RSC_C_PWR, RSC_C_PIN, RSC_C_LOST, RSC_C_CMP,
    RSC_C_DOG, RSC_C_FLASH, RSC_C_RTC, RSC_C_SOFT
  } rsc_cause_e;

endpackage

/* File: hdl/rsc_reset_source_controller.sv */
// Purpose: gathers reset sources, drives system reset, records the cause
// Assumes: sources from other clocks are levels; flash and dog inputs
//   come from logic on clk_in
// Notes: the cause register lives outside the system reset it creates
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_source_controller #(
  parameter int HOLD_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // asynchronous levels
  input wire logic reset_pin_n_in,
  input wire logic system_clk_in,
  input wire logic comparator_trip_n_in,
  input wire logic supply_low_in,
  // same-clock sources
  input wire logic low_power_in,
  input wire logic comparator_wake_en_in,
  input wire logic dog_expire_in,
  input wire logic dog_disable_in,
  input wire logic flash_write_in,
  input wire logic program_store_write_enable_in,
  input wire logic flash_above_lock_in,
  input wire logic code_data_read_in,
  input wire logic fetch_in,
  input wire logic security_block_in,
  input wire logic supply_monitor_on_in,
  input wire logic rtc_alarm_compare_in,
  input wire logic rtc_alarm_en_in,
  input wire logic rtc_osc_slow_in,
  input wire logic rtc_lost_detect_en_in,
  // outputs
  output logic sys_reset_out,
  output logic [15:0] reset_vector_out,
  output logic reset_pin_drive_out,
  output logic reset_pin_oe_n_out,
  output logic dog_enable_out,
  output logic dog_tick_out
);

  // ***********************************************************
  // input synchronisers
  // ***********************************************************
  localparam int NSYNC = 4;
  localparam logic [NSYNC-1:0] SYNC_IDLE = 4'h5;
  logic [NSYNC-1:0] async_raw;
  logic [NSYNC-1:0] sync_s1;
  logic [NSYNC-1:0] sync_s2;
  logic [NSYNC-1:0] sync_s3;
  logic [NSYNC-1:0] sync_level;

  assign async_raw = {supply_low_in, comparator_trip_n_in,
                      system_clk_in, reset_pin_n_in};

  // a change counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          sync_s1[gi] <= SYNC_IDLE[gi];
          sync_s2[gi] <= SYNC_IDLE[gi];
          sync_s3[gi] <= SYNC_IDLE[gi];
          sync_level[gi] <= SYNC_IDLE[gi];
        end else begin
          sync_s1[gi] <= async_raw[gi];
          sync_s2[gi] <= sync_s1[gi];
          sync_s3[gi] <= sync_s2[gi];
          if (sync_s2[gi] == sync_s3[gi]) begin
            sync_level[gi] <= sync_s3[gi];
          end
        end
      end
    end
  endgenerate

  logic pin_low;
  logic system_clk_level;
  logic cmp_low;
  logic supply_low;
  assign pin_low = ~sync_level[0];
  assign system_clk_level = sync_level[1];
  assign cmp_low = ~sync_level[2];
  assign supply_low = sync_level[3];

  // ***********************************************************
  // enables and flags
  // ***********************************************************
  logic pwr_en;
  logic lost_en;
  logic cmp_en;
  logic rtc_en;
  logic [7:0] cause_flags;
  logic soft_req;
  rsc_pkg::rsc_state_e state;
  rsc_pkg::rsc_cause_e cause;
  logic [15:0] hold_cnt;

  logic bus_write;
  logic bus_hit;
  assign bus_hit = (paddr_in == rsc_pkg::RSC_CAUSE_ADDR);
  assign bus_write = psel_in & penable_in & pready_out & pwrite_in &
                     bus_hit;

  // enables survive every sequenced reset; a power reset reloads only pwr_en
  // enables kept across resets
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwr_en <= rsc_pkg::RSC_PWR_EN_RST;
      lost_en <= rsc_pkg::RSC_LOST_EN_RST;
      cmp_en <= rsc_pkg::RSC_CMP_EN_RST;
      rtc_en <= rsc_pkg::RSC_RTC_EN_RST;
    end else if (state == rsc_pkg::RSC_HOLD &&
                 cause == rsc_pkg::RSC_C_PWR) begin
      pwr_en <= rsc_pkg::RSC_PWR_EN_RST;
    end else if (bus_write) begin
      pwr_en <= pwdata_in[rsc_pkg::RSC_PWR_BIT];
      lost_en <= pwdata_in[rsc_pkg::RSC_LOST_BIT];
      cmp_en <= pwdata_in[rsc_pkg::RSC_CMP_BIT];
      rtc_en <= pwdata_in[rsc_pkg::RSC_RTC_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      soft_req <= 1'b0;
    end else if (bus_write && pwdata_in[rsc_pkg::RSC_SOFT_BIT]) begin
      soft_req <= 1'b1;
    end else if (state == rsc_pkg::RSC_RUN) begin
      soft_req <= 1'b0;
    end
  end

  // ***********************************************************
  // lost clock one-shot
  // ***********************************************************
  logic lost_active;
  logic system_clk_prev;
  logic [12:0] lost_cnt;
  logic lost_trip;

  assign lost_active = lost_en & ~low_power_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      system_clk_prev <= 1'b0;
      lost_cnt <= 13'h0000;
    end else begin
      system_clk_prev <= system_clk_level;
      if (!lost_active || system_clk_prev != system_clk_level ||
          state == rsc_pkg::RSC_HOLD) begin
        lost_cnt <= 13'h0000;
      end else if (lost_cnt != 13'(rsc_pkg::RSC_LOST_CYCLES)) begin
        lost_cnt <= lost_cnt + 13'h0001;
      end
    end
  end
  assign lost_trip = lost_active &&
                     lost_cnt == 13'(rsc_pkg::RSC_LOST_CYCLES);

  // ***********************************************************
  // source qualification
  // ***********************************************************
  logic pwr_trip;
  logic cmp_trip;
  logic dog_trip;
  logic flash_trip;
  logic rtc_trip;

  // supply monitor is off in sleep
  assign pwr_trip = pwr_en & ~low_power_in & supply_low;
  // low power only as wake source
  assign cmp_trip = cmp_en & cmp_low &
                    (~low_power_in | comparator_wake_en_in);
  assign dog_trip = dog_enable_out & ~low_power_in & dog_expire_in;
  assign flash_trip =
    (flash_write_in & program_store_write_enable_in &
     flash_above_lock_in) |
    (code_data_read_in & flash_above_lock_in) |
    (fetch_in & flash_above_lock_in) |
    security_block_in |
    (flash_write_in & ~supply_monitor_on_in);
  assign rtc_trip = rtc_en &
                    ((rtc_alarm_compare_in & rtc_alarm_en_in) |
                     (rtc_osc_slow_in & rtc_lost_detect_en_in));

  rsc_pkg::rsc_cause_e next_cause;
  always_comb begin
    next_cause = rsc_pkg::RSC_C_NONE;
    if (pwr_trip) begin
      next_cause = rsc_pkg::RSC_C_PWR;
    end else if (pin_low) begin
      next_cause = rsc_pkg::RSC_C_PIN;
    end else if (lost_trip) begin
      next_cause = rsc_pkg::RSC_C_LOST;
    end else if (cmp_trip) begin
      next_cause = rsc_pkg::RSC_C_CMP;
    end else if (dog_trip) begin
      next_cause = rsc_pkg::RSC_C_DOG;
    end else if (flash_trip) begin
      next_cause = rsc_pkg::RSC_C_FLASH;
    end else if (rtc_trip) begin
      next_cause = rsc_pkg::RSC_C_RTC;
    end else if (soft_req) begin
      next_cause = rsc_pkg::RSC_C_SOFT;
    end
  end

  // pin, supply and comparator levels keep the reset in force while asserted
  logic cause_held;
  always_comb begin
    case (cause)
      rsc_pkg::RSC_C_PWR: cause_held = supply_low | pin_low;
      rsc_pkg::RSC_C_PIN: cause_held = pin_low;
      rsc_pkg::RSC_C_CMP: cause_held = cmp_en & cmp_low;
      default: cause_held = 1'b0;
    endcase
  end

  // ***********************************************************
  // reset sequencer
  // ***********************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= rsc_pkg::RSC_RUN;
      cause <= rsc_pkg::RSC_C_NONE;
      hold_cnt <= 16'h0000;
    end else begin
      case (state)
        rsc_pkg::RSC_RUN: begin
          if (next_cause != rsc_pkg::RSC_C_NONE) begin
            state <= rsc_pkg::RSC_HOLD;
            cause <= next_cause;
            hold_cnt <= 16'(HOLD_CYCLES - 1);
          end
        end
        rsc_pkg::RSC_HOLD: begin
          if (hold_cnt != 16'h0000) begin
            hold_cnt <= hold_cnt - 16'h0001;
          end else if (!cause_held) begin
            // released only once cause_held drops (supply, pin or comparator level clear)
            state <= rsc_pkg::RSC_RUN;
          end
        end
        default: begin
          state <= rsc_pkg::RSC_RUN;
        end
      endcase
    end
  end

  logic leaving;
  assign leaving = state == rsc_pkg::RSC_HOLD && hold_cnt == 16'h0000 &&
                   !cause_held;

  // only the latest cause left set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cause_flags <= 8'h02;
    end else if (leaving) begin
      cause_flags <= 8'h00;
      case (cause)
        rsc_pkg::RSC_C_PWR: cause_flags[rsc_pkg::RSC_PWR_BIT] <= 1'b1;
        rsc_pkg::RSC_C_PIN: cause_flags[rsc_pkg::RSC_PIN_BIT] <= 1'b1;
        rsc_pkg::RSC_C_LOST: cause_flags[rsc_pkg::RSC_LOST_BIT] <= 1'b1;
        rsc_pkg::RSC_C_CMP: cause_flags[rsc_pkg::RSC_CMP_BIT] <= 1'b1;
        rsc_pkg::RSC_C_DOG: cause_flags[rsc_pkg::RSC_DOG_BIT] <= 1'b1;
        rsc_pkg::RSC_C_FLASH: cause_flags[rsc_pkg::RSC_FLASH_BIT] <= 1'b1;
        rsc_pkg::RSC_C_RTC: cause_flags[rsc_pkg::RSC_RTC_BIT] <= 1'b1;
        rsc_pkg::RSC_C_SOFT: cause_flags[rsc_pkg::RSC_SOFT_BIT] <= 1'b1;
        default: cause_flags <= 8'h00;
      endcase
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // every reset restarts at the fixed vector
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sys_reset_out <= 1'b1;
      reset_vector_out <= rsc_pkg::RSC_RESET_VECTOR;
    end else begin
      sys_reset_out <= (state == rsc_pkg::RSC_RUN) ?
                       (next_cause != rsc_pkg::RSC_C_NONE) : !leaving;
      reset_vector_out <= rsc_pkg::RSC_RESET_VECTOR;
    end
  end

  // pin driven only for power resets
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reset_pin_drive_out <= 1'b0;
      reset_pin_oe_n_out <= 1'b0;
    end else begin
      reset_pin_drive_out <= 1'b0;
      reset_pin_oe_n_out <= !(state == rsc_pkg::RSC_HOLD &&
                              cause == rsc_pkg::RSC_C_PWR && supply_low);
    end
  end

  // watchdog up enabled, clock divided by twelve
  logic [3:0] div_cnt;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dog_enable_out <= 1'b1;
    end else if (state == rsc_pkg::RSC_HOLD) begin
      dog_enable_out <= 1'b1;
    end else if (dog_disable_in) begin
      dog_enable_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || state == rsc_pkg::RSC_HOLD) begin
      div_cnt <= 4'h0;
      dog_tick_out <= 1'b0;
    end else begin
      dog_tick_out <= div_cnt == 4'(rsc_pkg::RSC_DOG_DIV - 1);
      if (div_cnt == 4'(rsc_pkg::RSC_DOG_DIV - 1)) begin
        div_cnt <= 4'h0;
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  // ***********************************************************
  // apb slave
  // ***********************************************************
  // one wait state keeps every bus output on a flip-flop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~bus_hit;
      if (psel_in && penable_in && !pready_out && bus_hit &&
          !pwrite_in) begin
        prdata_out <= {24'h000000, cause_flags};
      end else begin
        prdata_out <= 32'h00000000;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verif/rsc_reset_source_controller_chk.sv */
// Purpose: port checks of the reset source controller
// Assumes: one clock domain, rst_in synchronous active high
// Notes: hold and quiet counts follow HOLD_CYCLES
`timescale 1ns/1ps
`default_nettype none
module rsc_chk #(
  parameter int HOLD_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic reset_pin_n_in,
  input wire logic supply_low_in,
  input wire logic sys_reset_out,
  input wire logic [15:0] reset_vector_out,
  input wire logic reset_pin_drive_out,
  input wire logic reset_pin_oe_n_out,
  input wire logic dog_enable_out,
  input wire logic dog_tick_out
);
  logic [7:0] hold_cnt;
  logic [7:0] quiet_cnt;
  logic [4:0] gap;
  logic gap_ok;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // helper counters
  // ****
  // saturate so a power reset never looks short
  always_ff @(posedge clk_in) begin
    if (rst_in) hold_cnt <= 8'hff;
    else if (!sys_reset_out) hold_cnt <= 8'h00;
    else if (hold_cnt != 8'hff) hold_cnt <= hold_cnt + 8'h01;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || supply_low_in) quiet_cnt <= 8'h00;
    else if (quiet_cnt != 8'hff) quiet_cnt <= quiet_cnt + 8'h01;
  end
  always_ff @(posedge clk_in) begin
    gap <= dog_tick_out ? 5'h01 : gap + 5'h01;
  end
  // a period is only judged between two ticks with no reset between
  always_ff @(posedge clk_in) begin
    if (rst_in || sys_reset_out || !dog_enable_out) gap_ok <= 1'b0;
    else if (dog_tick_out) gap_ok <= 1'b1;
  end
  // ****
  // assertions
  // ****
  chk_pin_forces_rst: assert property (
    !reset_pin_n_in [*7] |-> sys_reset_out)
    else $error("pin held low but no system reset");
  chk_pin_left_alone: assert property (
    quiet_cnt > HOLD_CYCLES + 8 |-> reset_pin_oe_n_out && !reset_pin_drive_out)
    else $error("reset pin driven by an internal reset");
  chk_soft_forces: assert property (
    psel_in && penable_in && pready_out && pwrite_in && !pslverr_out &&
    pwdata_in[rsc_pkg::RSC_SOFT_BIT] |-> ##[1:3] sys_reset_out)
    else $error("software request gave no reset");
  chk_min_hold: assert property (
    $fell(sys_reset_out) |-> hold_cnt >= HOLD_CYCLES)
    else $error("system reset shorter than hold time");
  chk_exit_state: assert property (
    $fell(sys_reset_out) |-> dog_enable_out &&
    reset_vector_out == rsc_pkg::RSC_RESET_VECTOR)
    else $error("reset exit with dog off or vector nonzero");
  chk_dog_period: assert property (
    dog_tick_out && gap_ok |-> gap == rsc_pkg::RSC_DOG_DIV)
    else $error("dog tick period wrong");
  chk_one_wait: assert property (
    $rose(psel_in && penable_in) |=> pready_out ##1 !pready_out)
    else $error("bus answer not after one wait state");
  chk_err_decode: assert property (
    pready_out |-> pslverr_out == (paddr_in != rsc_pkg::RSC_CAUSE_ADDR))
    else $error("bus error flag does not match decode");
  chk_read_idle: assert property (
    !pready_out || pslverr_out |-> prdata_out == 32'h00000000)
    else $error("read data outside a good answer");
endmodule
bind rsc_reset_source_controller rsc_chk #(.HOLD_CYCLES(HOLD_CYCLES))
    i_rsc_chk (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .reset_pin_n_in(reset_pin_n_in), .supply_low_in(supply_low_in),
  .sys_reset_out(sys_reset_out), .reset_vector_out(reset_vector_out),
  .reset_pin_drive_out(reset_pin_drive_out),
  .reset_pin_oe_n_out(reset_pin_oe_n_out),
  .dog_enable_out(dog_enable_out), .dog_tick_out(dog_tick_out));
`default_nettype wire

/* File: verif/rsc_pin_partner.sv */
// Purpose: outside circuitry on the active-low reset pin
// Assumes: the board has a pull-up on the pin
// Notes: the bench decides how long the pin is held low
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_partner (
  input wire logic pull_low_in,
  input wire logic dev_oe_n_in,
  input wire logic dev_drive_in,
  output logic pin_n_out
);
  // ****
  // pin wire
  // ****
  // forced reset, pull-up idle
  assign pin_n_out = !pull_low_in && (dev_oe_n_in || dev_drive_in);
endmodule
`default_nettype wire

/* File: verif/rsc_reset_source_controller_tb.sv */
// Purpose: self-checking bench of the reset source controller
// Assumes: 40 MHz clock, short hold time
// Notes: lost clock cases take some 16000 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module rsc_reset_source_controller_tb;
  localparam int HOLD = 4;
  localparam logic [11:0] A = rsc_pkg::RSC_CAUSE_ADDR;
  int error_cnt = 0;
  int num_checks = 0;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0, prdata;
  logic pready, pslverr, pin_n, sys_rst, drv, oe_n, dog_en;
  logic sclk = 1'b0;
  logic sclk_run, trip_n, sup_low, lp, wake, expire, dog_off, pull;
  logic alarm, alarm_en, osc_slow, lost_det;
  logic [6:0] fl;
  logic [6:0] pats [5] = '{7'h71, 7'h19, 7'h15, 7'h03, 7'h40};
  always #12.5 clk_in = ~clk_in;
  logic sdiv = 1'b0;
  // half rate is too fast for the filtered synchroniser to follow
  always @(posedge clk_in) if (sclk_run) begin
    sdiv <= ~sdiv;
    if (sdiv) sclk <= ~sclk;
  end
  rsc_reset_source_controller #(.HOLD_CYCLES(HOLD))
      i_rsc_reset_source_controller (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .reset_pin_n_in(pin_n), .system_clk_in(sclk),
    .comparator_trip_n_in(trip_n), .supply_low_in(sup_low),
    .low_power_in(lp), .comparator_wake_en_in(wake),
    .dog_expire_in(expire), .dog_disable_in(dog_off),
    .flash_write_in(fl[6]), .program_store_write_enable_in(fl[5]),
    .flash_above_lock_in(fl[4]), .code_data_read_in(fl[3]),
    .fetch_in(fl[2]), .security_block_in(fl[1]),
    .supply_monitor_on_in(fl[0]), .rtc_alarm_compare_in(alarm),
    .rtc_alarm_en_in(alarm_en), .rtc_osc_slow_in(osc_slow),
    .rtc_lost_detect_en_in(lost_det), .sys_reset_out(sys_rst),
    .reset_vector_out(), .reset_pin_drive_out(drv),
    .reset_pin_oe_n_out(oe_n), .dog_enable_out(dog_en),
    .dog_tick_out());
  rsc_pin_partner i_rsc_pin_partner (.pull_low_in(pull),
    .dev_oe_n_in(oe_n), .dev_drive_in(drv), .pin_n_out(pin_n));
  // ****
  // shared tasks
  // ****
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    $display("unexpected wait exp done got timeout");
    end_of_test();
  endtask
  task automatic clear_src();
    {trip_n, sclk_run, sup_low, lp, wake, expire, dog_off} <= 7'h60;
    {pull, alarm, alarm_en, osc_slow, lost_det} <= 5'h00;
    fl <= 7'h01;
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= ad;
    pwd <= wd;
    @(posedge clk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, A, {24'h0, v}, d, e);
  endtask
  task automatic rd_chk(input logic [7:0] ex);
    logic [31:0] d;
    logic e;
    apb(1'b0, A, 32'h0, d, e);
    `CHK("cause", {24'h0, ex}, d)
  endtask
  task automatic no_rst(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_in);
      if (sys_rst !== 1'b0) seen = 1'b1;
    end
    `CHK("spurious reset", 1'b0, seen)
  endtask
  // level sources are lifted hold cycles after the reset is seen
  task automatic expect_rst(input logic [7:0] ex, input int hold);
    int n;
    n = 0;
    while (sys_rst !== 1'b1 && n < 9000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 9000) hang();
    repeat (hold) @(posedge clk_in);
    `CHK("reset held", 1'b1, sys_rst)
    clear_src();
    n = 0;
    while (sys_rst !== 1'b0 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 200) hang();
    rd_chk(ex);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_power();
    logic [31:0] d;
    logic e;
    rd_chk(8'h02);
    apb(1'b0, A + 12'h004, 32'h0, d, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, d)
    apb(1'b1, A ^ 12'h100, 32'h10, d, e);
    no_rst(8);
  endtask
  task automatic t_soft();
    dog_off <= 1'b1;
    @(posedge clk_in);
    dog_off <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK("dog off", 1'b0, dog_en)
    wr(8'h12);
    expect_rst(8'h10, 1);
    `CHK("dog on", 1'b1, dog_en)
  endtask
  task automatic t_pin();
    lp <= 1'b1;
    pull <= 1'b1;
    expect_rst(8'h01, 40);
  endtask
  task automatic t_lost();
    wr(8'h06);
    sclk_run <= 1'b0;
    no_rst(3990);
    expect_rst(8'h04, 1);
    lp <= 1'b1;
    sclk_run <= 1'b0;
    no_rst(4200);
    lp <= 1'b0;
    expect_rst(8'h04, 1);
    wr(8'h02);
    sclk_run <= 1'b0;
    no_rst(4200);
    sclk_run <= 1'b1;
  endtask
  task automatic t_cmp();
    // trip input settled high before its reset is enabled
    wr(8'h22);
    lp <= 1'b1;
    trip_n <= 1'b0;
    no_rst(20);
    wake <= 1'b1;
    expect_rst(8'h20, 1);
    wr(8'h02);
    trip_n <= 1'b0;
    no_rst(20);
    trip_n <= 1'b1;
  endtask
  task automatic t_dog();
    lp <= 1'b1;
    expire <= 1'b1;
    @(posedge clk_in);
    expire <= 1'b0;
    no_rst(20);
    lp <= 1'b0;
    expire <= 1'b1;
    @(posedge clk_in);
    expire <= 1'b0;
    expect_rst(8'h08, 1);
  endtask
  task automatic t_flash();
    fl <= 7'h61;
    no_rst(20);
    for (int i = 0; i < 5; i++) begin
      fl <= pats[i];
      expect_rst(8'h40, 1);
    end
  endtask
  task automatic t_rtc();
    wr(8'h82);
    lp <= 1'b1;
    alarm <= 1'b1;
    alarm_en <= 1'b1;
    expect_rst(8'h80, 1);
    osc_slow <= 1'b1;
    lost_det <= 1'b1;
    expect_rst(8'h80, 1);
  endtask
  task automatic t_supply();
    wr(8'h00);
    sup_low <= 1'b1;
    no_rst(20);
    sup_low <= 1'b0;
    // monitor level is settled before power-fail is selected
    wr(8'h02);
    repeat (4) @(posedge clk_in);
    sup_low <= 1'b1;
    expect_rst(8'h02, 20);
  endtask
  initial begin
    clear_src();
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_power();
    t_soft();
    t_pin();
    t_lost();
    t_cmp();
    t_dog();
    t_flash();
    t_rtc();
    t_supply();
    end_of_test();
  end
endmodule
`default_nettype wire
